// file: pkg/lades_pkg.sv
// Package: register map, field layout and reset values of the lane status block
package lades_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          LADES_ADDR_W     = 16;
  localparam int          LADES_DATA_W     = 32;
  localparam int          LADES_LANES      = 8;
  localparam int          LADES_CNT_W      = 8;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [13:0] LADES_IDX_DESKEW = 14'h046C;
  localparam logic [13:0] LADES_IDX_DISP   = 14'h046D;
  localparam logic [13:0] LADES_IDX_THRESH = 14'h0480;
  localparam logic [13:0] LADES_IDX_CTRL   = 14'h0481;
  localparam logic [13:0] LADES_IDX_IRQ_ST = 14'h0482;
  localparam logic [13:0] LADES_IDX_IRQ_MK = 14'h0483;
  localparam logic [13:0] LADES_IDX_CNT0   = 14'h0490;

  // ==========================================================================
  // Control register fields
  localparam int          LADES_CTRL_SKIP  = 0;
  localparam int          LADES_CTRL_CLR   = 1;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  LADES_RST_FLAGS  = 8'h00;
  localparam logic [7:0]  LADES_RST_DESKEW = 8'h00;
  localparam logic [7:0]  LADES_RST_THRESH = 8'hFF;
  localparam logic [7:0]  LADES_RST_MASK   = 8'h00;
  localparam logic [7:0]  LADES_RST_CNT    = 8'h00;
  localparam logic        LADES_RST_SKIP   = 1'b0;

  // ==========================================================================
  // APB decoding
  function automatic logic lades_hit(input logic [15:0] addr, input logic [13:0] idx);
    return addr == {idx, 2'b00};
  endfunction

endpackage

// file: rtl/lades_top.sv
// Lane deskew and running-disparity error status block with APB slave
// What this block does
// R1 - Report per-lane deskew achieved bit, read-only
// R2 - Software ignores deskew bits when alignment skipped
// R3 - Flag lane when error count reaches threshold
// R4 - Flag stays low while count below threshold
// R5 - Disparity flags register, lane n bit n
// R6 - Independent counter per lane against shared threshold
`timescale 1ns/1ps
`default_nettype none

module lades_top #(
  parameter int LANES = 8,
  parameter int CNT_W = 8
) (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [lades_pkg::LADES_ADDR_W-1:0] paddr,
  input  wire logic [lades_pkg::LADES_DATA_W-1:0] pwdata,
  output logic                                 pready,
  output logic [lades_pkg::LADES_DATA_W-1:0]   prdata,
  output logic                                 pslverr,
  input  wire logic [LANES-1:0]                lane_deskew_ok,
  input  wire logic [LANES-1:0]                lane_disp_err,
  output logic                                 skip_lane_alignment_sequence,
  output logic [LANES-1:0]                     lane_disparity_error_flag,
  output logic                                 irq
);
  import lades_pkg::*;

  // ==========================================================================
  // State
  logic [CNT_W-1:0] cnt_reg [LANES];
  logic [CNT_W-1:0] cnt_next [LANES];
  logic [LANES-1:0] flag_reg, flag_next;
  logic [LANES-1:0] deskew_reg, deskew_next;
  logic [LANES-1:0] irq_st_reg, irq_st_next;
  logic [LANES-1:0] irq_mk_reg, irq_mk_next;
  logic [7:0]       thr_reg, thr_next;
  logic             skip_reg, skip_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             err_reg, err_next;
  logic [LANES-1:0] cmp_vec;
  logic             wr_acc, rd_setup, cnt_clr;
  logic [31:0]      rd_val;
  logic             rd_ok;

  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign cnt_clr  = wr_acc && lades_hit(paddr, LADES_IDX_CTRL) && pwdata[LADES_CTRL_CLR];

  // ==========================================================================
  // Error counters and threshold compare
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      cnt_next[i] = cnt_reg[i];
      // Saturate so a long burst never wraps below the threshold
      if (cnt_clr) begin
        cnt_next[i] = LADES_RST_CNT[CNT_W-1:0];
      end else if (lane_disp_err[i] && (cnt_reg[i] != {CNT_W{1'b1}})) begin
        cnt_next[i] = cnt_reg[i] + CNT_W'(1); // R6
      end
      cmp_vec[i] = (CNT_W'(thr_reg) <= cnt_reg[i]); // R3 R4 R6
    end
    flag_next   = cmp_vec; // R3 R4
    deskew_next = lane_deskew_ok; // R1
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < LANES; i++) begin
        cnt_reg[i] <= LADES_RST_CNT[CNT_W-1:0];
      end
      flag_reg   <= LADES_RST_FLAGS[LANES-1:0]; // R5
      deskew_reg <= LADES_RST_DESKEW[LANES-1:0];
    end else begin
      cnt_reg    <= cnt_next;
      flag_reg   <= flag_next;
      deskew_reg <= deskew_next;
    end
  end

  // ==========================================================================
  // Software registers and interrupt
  always_comb begin
    thr_next    = thr_reg;
    skip_next   = skip_reg;
    irq_mk_next = irq_mk_reg;
    irq_st_next = irq_st_reg;
    if (wr_acc && lades_hit(paddr, LADES_IDX_THRESH)) begin
      thr_next = pwdata[7:0];
    end
    if (wr_acc && lades_hit(paddr, LADES_IDX_CTRL)) begin
      skip_next = pwdata[LADES_CTRL_SKIP];
    end
    if (wr_acc && lades_hit(paddr, LADES_IDX_IRQ_MK)) begin
      irq_mk_next = pwdata[LANES-1:0];
    end
    if (wr_acc && lades_hit(paddr, LADES_IDX_IRQ_ST)) begin
      irq_st_next = irq_st_reg & ~pwdata[LANES-1:0];
    end
    // Set after clear so a rising flag in the clear cycle survives
    irq_st_next = irq_st_next | (flag_next & ~flag_reg);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      thr_reg    <= LADES_RST_THRESH;
      skip_reg   <= LADES_RST_SKIP;
      irq_mk_reg <= LADES_RST_MASK[LANES-1:0];
      irq_st_reg <= '0;
    end else begin
      thr_reg    <= thr_next;
      skip_reg   <= skip_next;
      irq_mk_reg <= irq_mk_next;
      irq_st_reg <= irq_st_next;
    end
  end

  // ==========================================================================
  // APB read path; data captured in setup so prdata comes from a flop
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (lades_hit(paddr, LADES_IDX_DESKEW)) begin
      rd_val[LANES-1:0] = deskew_reg; // R1
    end else if (lades_hit(paddr, LADES_IDX_DISP)) begin
      rd_val[LANES-1:0] = flag_reg; // R5
    end else if (lades_hit(paddr, LADES_IDX_THRESH)) begin
      rd_val[7:0] = thr_reg;
    end else if (lades_hit(paddr, LADES_IDX_CTRL)) begin
      rd_val[LADES_CTRL_SKIP] = skip_reg;
    end else if (lades_hit(paddr, LADES_IDX_IRQ_ST)) begin
      rd_val[LANES-1:0] = irq_st_reg;
    end else if (lades_hit(paddr, LADES_IDX_IRQ_MK)) begin
      rd_val[LANES-1:0] = irq_mk_reg;
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < LANES; i++) begin
        if (lades_hit(paddr, LADES_IDX_CNT0 + 14'(i))) begin
          rd_val[CNT_W-1:0] = cnt_reg[i];
          rd_ok = !pwrite;
        end
      end
    end
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (rd_setup) begin
      rdata_next = pwrite ? 32'h0000_0000 : rd_val;
      // Read-only status words refuse writes
      err_next   = !rd_ok || (pwrite && (lades_hit(paddr, LADES_IDX_DESKEW) ||
                                         lades_hit(paddr, LADES_IDX_DISP)));
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign pready                       = 1'b1;
  assign prdata                       = rdata_reg;
  assign pslverr                      = err_reg && psel && penable;
  assign skip_lane_alignment_sequence = skip_reg; // R2
  assign lane_disparity_error_flag    = flag_reg;
  assign irq                          = |(irq_st_reg & irq_mk_reg);

  // ==========================================================================
  // Assertions
  // First edge out of reset still shows the reset value, not the lane input
  a_deskew_follows: assert property (@(posedge clk) disable iff (sys_rst) // R1
    !$past(sys_rst) |-> deskew_reg == $past(lane_deskew_ok))
    else $error("deskew bits do not follow lane input");

  a_flag_sets: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (cnt_reg[7] >= thr_reg) |=> flag_reg[7])
    else $error("lane 7 flag not set at threshold");

  a_flag_low: assert property (@(posedge clk) disable iff (sys_rst) // R4
    (cnt_reg[1] < thr_reg) |=> !flag_reg[1])
    else $error("lane 1 flag set below threshold");

  a_flag_read: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (rd_setup && !pwrite && lades_hit(paddr, LADES_IDX_DISP)) |=>
      (prdata == {24'h000000, $past(flag_reg)}))
    else $error("flag register read mismatch");

  a_count_inc: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (lane_disp_err[2] && !cnt_clr && cnt_reg[2] != 8'hFF) |=>
      cnt_reg[2] == $past(cnt_reg[2]) + 8'h01)
    else $error("lane 2 counter did not advance");

  a_count_sat: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (cnt_reg[3] == 8'hFF && !cnt_clr) |=> cnt_reg[3] == 8'hFF)
    else $error("lane 3 counter left saturation");

  a_irq_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(flag_reg[4]) |-> irq_st_reg[4])
    else $error("lane 4 status not set on flag rise");

  a_write_refused: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (rd_setup && pwrite && lades_hit(paddr, LADES_IDX_DISP)) |=> err_reg)
    else $error("write to flag register not refused");

  c_flag_rise: cover property (@(posedge clk) disable iff (sys_rst)
    !flag_reg[3] ##1 flag_reg[3]);
  c_cnt_sat:   cover property (@(posedge clk) disable iff (sys_rst)
    cnt_reg[3] == 8'hFF);
  c_irq_seen:  cover property (@(posedge clk) disable iff (sys_rst) irq);
  c_cnt_clear: cover property (@(posedge clk) disable iff (sys_rst)
    cnt_clr && cnt_reg[0] != 8'h00);

endmodule

`default_nettype wire

// file: bench/lades_lane_model.sv
// Lane-side model: aligner deskew status and bursts of disparity errors
`timescale 1ns/1ps
`default_nettype none
module lades_lane_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic       burst,
  input  wire logic [7:0] deskew_in,
  output logic [7:0]      lane_deskew_ok,
  output logic [7:0]      lane_disp_err
);
  int step = 99;
  // ==========================================================================
  // Burst timing
  always @(posedge clk) begin
    lane_deskew_ok <= deskew_in;
    if (fire)
      step <= 0;
    else if (step < 99)
      step <= step + 1;
  end
  // Lane n sees n single-cycle errors, so counts differ per lane
  // Burst errors every lane on every cycle, long enough to saturate
  always_comb for (int n = 0; n < 8; n++) lane_disp_err[n] = (step < n) || burst;
endmodule
`default_nettype wire

// file: bench/lane_align_error_status_tb_top.sv
// Testbench: APB access to lane deskew and disparity status
`timescale 1ns/1ps
`default_nettype none
module lane_align_error_status_tb_top;
  import lades_pkg::*;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, burst = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0]  dsk = '0, ok, err, flags;
  logic        pready, pslverr, skip, irq;
  int          n_errors = 0, n_checks = 0, cyc = 0, seed = 37804;
  logic [32:0] q[$];
  always #4 clk = ~clk;
  lades_top lades_top_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .lane_deskew_ok(ok), .lane_disp_err(err),
    .skip_lane_alignment_sequence(skip), .lane_disparity_error_flag(flags), .irq(irq));
  lades_lane_model lades_lane_model_i (.clk(clk), .fire(fire), .burst(burst), .deskew_in(dsk),
    .lane_deskew_ok(ok), .lane_disp_err(err));
  // ==========================================================================
  // Compare and verdict
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // APB master; every transfer notes {pslverr, read data} expected
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d,
                     input logic [32:0] exp);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    q.push_back(exp);
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask
  // ==========================================================================
  // Output watcher and hang guard
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1)
      check({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    apb(0, LADES_IDX_DISP, 0, 33'h0);
    for (int i = 0; i < 4; i++) begin
      dsk <= 8'($random(seed));
      repeat (3) @(posedge clk);
      apb(0, LADES_IDX_DESKEW, 0, {25'h0, dsk});
    end
    apb(1, LADES_IDX_IRQ_MK, 32'hFF, 0);
    apb(1, LADES_IDX_THRESH, 32'h3, 0);
    apb(0, LADES_IDX_DISP, 0, 33'h0);
    fire <= 1;
    @(posedge clk);
    fire <= 0;
    repeat (12) @(posedge clk);
    apb(0, LADES_IDX_DISP, 0, 33'hF8);
    #1 check({32'h0, irq}, 33'h1);
    check({25'h0, flags}, 33'hF8);
    apb(0, LADES_IDX_CNT0 + 14'h5, 0, 33'h5);
    apb(1, LADES_IDX_IRQ_ST, 32'hFF, 0);
    #1 check({32'h0, irq}, 33'h0);
    apb(1, LADES_IDX_THRESH, 32'h8, 0);
    repeat (3) @(posedge clk);
    apb(0, LADES_IDX_DISP, 0, 33'h0);
    apb(1, LADES_IDX_THRESH, 32'h7, 0);
    repeat (3) @(posedge clk);
    apb(1, LADES_IDX_DISP, 32'hFFFF, 33'h100000000);
    apb(0, LADES_IDX_DISP, 0, 33'h80);
    apb(0, 14'h0001, 0, 33'h100000000);
    apb(1, LADES_IDX_CTRL, 32'h2, 0);
    repeat (3) @(posedge clk);
    apb(0, LADES_IDX_DISP, 0, 33'h0);
    burst <= 1;
    repeat (300) @(posedge clk);
    burst <= 0;
    repeat (3) @(posedge clk);
    apb(0, LADES_IDX_CNT0 + 14'h3, 0, 33'hFF);
    apb(0, LADES_IDX_DISP, 0, 33'hFF);
    apb(1, LADES_IDX_CTRL, 32'h1, 0);
    apb(0, LADES_IDX_CTRL, 0, 33'h1);
    #1 check({32'h0, skip}, 33'h1);
    check({25'h0, flags}, 33'hFF);
    // Alignment skipped: deskew bits mean nothing now, so none are compared
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule
`default_nettype wire
